/* hw/psr_defs.svh */
// Purpose : named timing and count constants of the supervisor block
// Assumes : 125 MHz reference clock, oscillator tick of about 33 us
// Notes   : times kept in their own units, counts derived from them
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// ********************************************************************
// clock and oscillator
// ********************************************************************
`define PSR_CLK_PERIOD_NS   8
`define PSR_OSC_PERIOD_NS   33000
`define PSR_OSC_PERIOD_US   33
`define PSR_CEIL_DIV(a, b)  (((a) + (b) - 1) / (b))

// ********************************************************************
// times in microseconds
// ********************************************************************
`define PSR_RST_MIN_US      25000
`define PSR_PWRUP_TYP_US    100000
`define PSR_WDOG_TYP_US     400000
`define PSR_NMI_MIN_US      200
`define PSR_CE_HOLD_US      100

// ********************************************************************
// counts of oscillator ticks, and clock cycles per tick
// ********************************************************************
`define PSR_TICK_CYCLES  (`PSR_OSC_PERIOD_NS / `PSR_CLK_PERIOD_NS)
`define PSR_RST_TICKS    `PSR_CEIL_DIV(`PSR_RST_MIN_US, `PSR_OSC_PERIOD_US)
`define PSR_PWRUP_TICKS  `PSR_CEIL_DIV(`PSR_PWRUP_TYP_US, `PSR_OSC_PERIOD_US)
`define PSR_WDOG_TICKS   (`PSR_WDOG_TYP_US / `PSR_OSC_PERIOD_US)
`define PSR_NMI_TICKS    `PSR_CEIL_DIV(`PSR_NMI_MIN_US, `PSR_OSC_PERIOD_US)
`define PSR_CE_TICKS     `PSR_CEIL_DIV(`PSR_CE_HOLD_US, `PSR_OSC_PERIOD_US)
`define PSR_NMI_SAMPLES  2'h3
`define PSR_PB_DEB_TICKS 3
// synchroniser reset: supply low, strobe open, button and enable off
`define PSR_PINS_IDLE    8'hDD

`endif

/* hw/psr_pkg.sv */
// Purpose : types shared by the supervisor block
// Assumes : nothing beyond the constants header
// Notes   : pin group travels as one packed struct
package psr_pkg;

  // ******************************************************************
  // pin group, after synchronisation
  // ******************************************************************
  typedef struct packed {
    logic supply_low;
    logic below_battery;
    logic sense_low;
    logic strobe_n;
    logic strobe_open;
    logic pushbutton_n;
    logic mode_backed;
    logic chip_enable_in_n;
  } psr_pins_type;

  // ******************************************************************
  // state machines
  // ******************************************************************
  typedef enum logic [1:0] {
    RS_HOLD,
    RS_STRETCH,
    RS_RUN
  } psr_rst_state_type;

  typedef enum logic [1:0] {
    CE_PASS,
    CE_HOLD,
    CE_LOCK
  } psr_ce_state_type;

endpackage

/* hw/psr_top.sv */
// Purpose : reset, watchdog, early warning and memory gate supervisor
// Assumes : comparator results arrive as asynchronous digital levels
// Notes   : internal oscillator is a tick divided from REF_CLK
`timescale 1ns/1ns
`default_nettype none
`include "psr_defs.svh"

module psr_top #(
  parameter int unsigned TICK_CYCLES  = `PSR_TICK_CYCLES,
  parameter int unsigned RST_TICKS    = `PSR_RST_TICKS,
  parameter int unsigned PWRUP_TICKS  = `PSR_PWRUP_TICKS,
  parameter int unsigned WDOG_TICKS   = `PSR_WDOG_TICKS,
  parameter int unsigned NMI_TICKS    = `PSR_NMI_TICKS,
  parameter int unsigned CE_TICKS     = `PSR_CE_TICKS,
  parameter int unsigned PB_DEB_TICKS = `PSR_PB_DEB_TICKS
) (
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic SUPPLY_LOW,
  input  wire logic SUPPLY_BELOW_BATTERY,
  input  wire logic SENSE_LOW,
  input  wire logic WATCHDOG_STROBE_N,
  input  wire logic STROBE_OPEN,
  input  wire logic PUSHBUTTON_RESET_N,
  input  wire logic RESET_MODE_SELECT,
  input  wire logic CHIP_ENABLE_IN_N,
  output var  logic RESET_OUT,
  output var  logic RESET_OUT_N,
  output var  logic INTERRUPT_N_O,
  output var  logic INTERRUPT_N_OE,
  output var  logic CHIP_ENABLE_OUT_N
);

  // ******************************************************************
  // input synchroniser
  // ******************************************************************
  psr_pkg::psr_pins_type sync1_q;
  psr_pkg::psr_pins_type pins_s;
  psr_pkg::psr_pins_type pins_raw;

  always_comb begin
    pins_raw.supply_low       = SUPPLY_LOW;
    pins_raw.below_battery    = SUPPLY_BELOW_BATTERY;
    pins_raw.sense_low        = SENSE_LOW;
    pins_raw.strobe_n         = WATCHDOG_STROBE_N;
    pins_raw.strobe_open      = STROBE_OPEN;
    pins_raw.pushbutton_n     = PUSHBUTTON_RESET_N;
    pins_raw.mode_backed      = RESET_MODE_SELECT;
    pins_raw.chip_enable_in_n = CHIP_ENABLE_IN_N;
  end

  // idle pattern: supply low, button and strobe released
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= `PSR_PINS_IDLE;
      pins_s  <= `PSR_PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      pins_s  <= sync1_q;
    end
  end

  logic backed;
  logic sense_gate;
  assign backed     = pins_s.mode_backed;
  assign sense_gate = backed && pins_s.sense_low;

  // ******************************************************************
  // oscillator tick
  // ******************************************************************
  logic [12:0] tick_cnt_q, tick_cnt_d;
  logic        tick_q, tick_d;

  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 13'h1;
    if (tick_cnt_q == 13'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 13'h0;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_q <= 13'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ******************************************************************
  // reset sequencer, watchdog and pushbutton
  // ******************************************************************
  psr_pkg::psr_rst_state_type rs_q, rs_d;
  logic [15:0] stretch_q, stretch_d;
  logic [15:0] wd_cnt_q, wd_cnt_d;
  logic [3:0]  pb_cnt_q, pb_cnt_d;
  logic        pwr_q, pwr_d;
  logic        strobe_prev_q;
  logic        strobe_fall;
  logic        wd_en;
  logic        wd_expire;
  logic        pb_block;
  logic        pb_pressed;
  logic        rst_out_q;
  logic        rst_out_n_q;

  assign strobe_fall = strobe_prev_q && !pins_s.strobe_n;
  // watchdog off with open strobe, supply low or backed sense low
  assign wd_en = !pins_s.strobe_open && !pins_s.supply_low
                 && !sense_gate;
  // a kick in the expiry cycle wins, the host was still in time
  assign wd_expire = (rs_q == psr_pkg::RS_RUN) && wd_en && tick_q
                     && !strobe_fall
                     && (wd_cnt_q == 16'(WDOG_TICKS - 1));
  assign pb_block = sense_gate || pins_s.below_battery;
  assign pb_pressed = (pb_cnt_q == 4'(PB_DEB_TICKS));

  always_comb begin
    rs_d      = rs_q;
    stretch_d = stretch_q;
    wd_cnt_d  = wd_cnt_q;
    pwr_d     = pwr_q;
    pb_cnt_d  = pb_cnt_q;
    // button debounce: held low for several ticks before it counts
    if (pb_block || pins_s.pushbutton_n) begin
      pb_cnt_d = 4'h0;
    end else if (tick_q && !pb_pressed) begin
      pb_cnt_d = pb_cnt_q + 4'h1;
    end
    if (pins_s.supply_low) begin
      pwr_d = 1'b1;
    end
    case (rs_q)
      psr_pkg::RS_HOLD: begin
        wd_cnt_d = 16'h0;
        if (!pins_s.supply_low && !pb_pressed) begin
          rs_d      = psr_pkg::RS_STRETCH;
          stretch_d = pwr_q ? 16'(PWRUP_TICKS)
                            : 16'(RST_TICKS);
          pwr_d     = 1'b0;
        end
      end
      psr_pkg::RS_STRETCH: begin
        wd_cnt_d = 16'h0;
        if (tick_q) begin
          stretch_d = stretch_q - 16'h1;
        end
        if (tick_q && stretch_q == 16'h1) begin
          rs_d = psr_pkg::RS_RUN;
        end
      end
      psr_pkg::RS_RUN: begin
        if (!wd_en || strobe_fall) begin
          wd_cnt_d = 16'h0;
        end else if (tick_q) begin
          wd_cnt_d = wd_cnt_q + 16'h1;
        end
        if (wd_expire) begin
          rs_d      = psr_pkg::RS_STRETCH;
          stretch_d = 16'(RST_TICKS);
          wd_cnt_d  = 16'h0;
        end
      end
      default: begin
        rs_d = psr_pkg::RS_HOLD;
      end
    endcase
    // supply loss or a pressed button override everything else
    if (pins_s.supply_low || pb_pressed) begin
      rs_d     = psr_pkg::RS_HOLD;
      wd_cnt_d = 16'h0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rs_q          <= psr_pkg::RS_HOLD;
      stretch_q     <= 16'h0;
      wd_cnt_q      <= 16'h0;
      pwr_q         <= 1'b1;
      pb_cnt_q      <= 4'h0;
      strobe_prev_q <= 1'b1;
      rst_out_q     <= 1'b1;
      rst_out_n_q   <= 1'b0;
    end else begin
      rs_q          <= rs_d;
      stretch_q     <= stretch_d;
      wd_cnt_q      <= wd_cnt_d;
      pwr_q         <= pwr_d;
      pb_cnt_q      <= pb_cnt_d;
      strobe_prev_q <= pins_s.strobe_n;
      rst_out_q     <= (rs_d != psr_pkg::RS_RUN);
      rst_out_n_q   <= (rs_d == psr_pkg::RS_RUN);
    end
  end

  assign RESET_OUT   = rst_out_q;
  // own flop, so the low-active pin has no gate behind it
  assign RESET_OUT_N = rst_out_n_q;

  // ******************************************************************
  // early warning interrupt
  // ******************************************************************
  logic [1:0]  low_cnt_q, low_cnt_d;
  logic [15:0] nmi_cnt_q, nmi_cnt_d;
  logic        nmi_act_q, nmi_act_d;
  logic        nmi_done_q, nmi_done_d;
  logic        armed_q, armed_d;
  logic        nmi_n_q, nmi_oe_q;
  logic        start_sense;
  logic        start_strobe;

  // sense samples only on ticks; a single high sample rearms it
  assign start_sense = tick_q && pins_s.sense_low && armed_q
                       && !nmi_done_q
                       && (low_cnt_q == `PSR_NMI_SAMPLES - 2'h1)
                       && !(backed && pins_s.supply_low);
  assign start_strobe = sense_gate && strobe_fall && armed_q;

  always_comb begin
    low_cnt_d  = low_cnt_q;
    nmi_cnt_d  = nmi_cnt_q;
    nmi_act_d  = nmi_act_q;
    nmi_done_d = nmi_done_q;
    armed_d    = armed_q;
    if (pins_s.below_battery) begin
      armed_d = 1'b0;
    end else if (!pins_s.supply_low) begin
      armed_d = 1'b1;
    end
    if (!pins_s.sense_low) begin
      low_cnt_d  = 2'h0;
      nmi_done_d = 1'b0;
    end else if (tick_q && low_cnt_q != `PSR_NMI_SAMPLES) begin
      low_cnt_d = low_cnt_q + 2'h1;
    end
    if (nmi_act_q) begin
      if (!pins_s.sense_low) begin
        nmi_act_d = 1'b0;
      end else if (tick_q) begin
        nmi_cnt_d = nmi_cnt_q + 16'h1;
        if (nmi_cnt_q == 16'(NMI_TICKS - 1)) begin
          nmi_act_d  = 1'b0;
          nmi_done_d = 1'b1;
        end
      end
    end else if (start_sense || start_strobe) begin
      nmi_act_d = 1'b1;
      nmi_cnt_d = 16'h0;
    end
    if (pins_s.below_battery) begin
      nmi_act_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      low_cnt_q  <= 2'h0;
      nmi_cnt_q  <= 16'h0;
      nmi_act_q  <= 1'b0;
      nmi_done_q <= 1'b0;
      armed_q    <= 1'b0;
      nmi_n_q    <= 1'b1;
      nmi_oe_q   <= 1'b0;
    end else begin
      low_cnt_q  <= low_cnt_d;
      nmi_cnt_q  <= nmi_cnt_d;
      nmi_act_q  <= nmi_act_d;
      nmi_done_q <= nmi_done_d;
      armed_q    <= armed_d;
      nmi_n_q    <= !nmi_act_d;
      // non-backed mode floats the pin once on battery
      nmi_oe_q   <= !pins_s.below_battery || backed;
    end
  end

  assign INTERRUPT_N_O  = nmi_n_q;
  assign INTERRUPT_N_OE = nmi_oe_q;

  // ******************************************************************
  // memory chip enable gate
  // ******************************************************************
  psr_pkg::psr_ce_state_type ce_q, ce_d;
  logic [15:0] ce_cnt_q, ce_cnt_d;
  logic        ce_out_q, ce_out_d;

  always_comb begin
    ce_d     = ce_q;
    ce_cnt_d = ce_cnt_q;
    ce_out_d = ce_out_q;
    case (ce_q)
      psr_pkg::CE_PASS: begin
        ce_out_d = pins_s.chip_enable_in_n;
        if (pins_s.supply_low) begin
          ce_cnt_d = 16'h0;
          // an access in flight may finish, within CE_TICKS ticks, before protection
          if (!ce_out_q) begin
            ce_d     = psr_pkg::CE_HOLD;
            ce_out_d = ce_out_q;
          end else begin
            ce_d     = psr_pkg::CE_LOCK;
            ce_out_d = 1'b1;
          end
        end
      end
      psr_pkg::CE_HOLD: begin
        if (tick_q) begin
          ce_cnt_d = ce_cnt_q + 16'h1;
        end
        if (pins_s.chip_enable_in_n
            || (tick_q && ce_cnt_q == 16'(CE_TICKS - 1))) begin
          ce_d     = psr_pkg::CE_LOCK;
          ce_out_d = 1'b1;
        end
      end
      psr_pkg::CE_LOCK: begin
        ce_out_d = 1'b1;
        if (!pins_s.supply_low) begin
          ce_d = psr_pkg::CE_PASS;
        end
      end
      default: begin
        ce_d     = psr_pkg::CE_LOCK;
        ce_out_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ce_q     <= psr_pkg::CE_LOCK;
      ce_cnt_q <= 16'h0;
      ce_out_q <= 1'b1;
    end else begin
      ce_q     <= ce_d;
      ce_cnt_q <= ce_cnt_d;
      ce_out_q <= ce_out_d;
    end
  end

  assign CHIP_ENABLE_OUT_N = ce_out_q;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_supply_reset;
    pins_s.supply_low |=> RESET_OUT && !RESET_OUT_N;
  endproperty
  a_supply_reset: assert property (p_supply_reset)
    else $error("reset not active with supply low");

  property p_wd_idle_in_reset;
    (rs_q != psr_pkg::RS_RUN) |-> (wd_cnt_q == 16'h0);
  endproperty
  a_wd_idle_in_reset: assert property (p_wd_idle_in_reset)
    else $error("watchdog counted during reset");

  property p_strobe_clears;
    (rs_q == psr_pkg::RS_RUN) && strobe_fall && !pins_s.supply_low
      && !pb_pressed
      |=> (wd_cnt_q == 16'h0) && (rs_q == psr_pkg::RS_RUN);
  endproperty
  a_strobe_clears: assert property (p_strobe_clears)
    else $error("strobe did not restart watchdog");

  property p_wd_expiry;
    wd_expire && !pins_s.supply_low && !pb_pressed
      |=> (rs_q == psr_pkg::RS_STRETCH)
          && (stretch_q == 16'(RST_TICKS)) ##1 RESET_OUT;
  endproperty
  a_wd_expiry: assert property (p_wd_expiry)
    else $error("watchdog expiry gave no reset stretch");

  property p_wd_disabled;
    (rs_q == psr_pkg::RS_RUN) && !wd_en |=> (wd_cnt_q == 16'h0);
  endproperty
  a_wd_disabled: assert property (p_wd_disabled)
    else $error("disabled watchdog kept counting");

  property p_pb_ignored;
    pb_block |=> (pb_cnt_q == 4'h0);
  endproperty
  a_pb_ignored: assert property (p_pb_ignored)
    else $error("blocked button was debounced");

  property p_sense_rise_ends;
    nmi_act_q && !pins_s.sense_low |=> !nmi_act_q ##1 INTERRUPT_N_O;
  endproperty
  a_sense_rise_ends: assert property (p_sense_rise_ends)
    else $error("interrupt outlived sense rising");

  property p_nmi_armed;
    $rose(nmi_act_q) |-> $past(armed_q);
  endproperty
  a_nmi_armed: assert property (p_nmi_armed)
    else $error("interrupt before supply reached trip");

  property p_ce_pass;
    (ce_q == psr_pkg::CE_PASS) && !pins_s.supply_low
      |=> (CHIP_ENABLE_OUT_N == $past(pins_s.chip_enable_in_n));
  endproperty
  a_ce_pass: assert property (p_ce_pass)
    else $error("chip enable not passed through");

  property p_ce_lock;
    (ce_q == psr_pkg::CE_PASS) && pins_s.supply_low && CHIP_ENABLE_OUT_N
      |=> CHIP_ENABLE_OUT_N [*2];
  endproperty
  a_ce_lock: assert property (p_ce_lock)
    else $error("inactive chip enable not locked");

  property p_battery_pin;
    pins_s.below_battery
      |=> INTERRUPT_N_O && (INTERRUPT_N_OE == $past(backed));
  endproperty
  a_battery_pin: assert property (p_battery_pin)
    else $error("interrupt pin wrong on battery");

endmodule
`default_nettype wire

/* verif/psr_host_model.sv */
// Purpose : host side, kicks the watchdog and straps the mode pin
// Assumes : kick period is a quarter of the watchdog timeout
// Notes   : a host held in reset cannot kick, so the count restarts
`timescale 1ns/1ns
`default_nettype none
module psr_host_model #(
  parameter int KICK_CYC = 10
) (
  input  wire logic clk,
  input  wire logic in_reset,
  input  wire logic kick_en,
  input  wire logic backed,
  output var  logic strobe_n,
  output var  logic mode_sel
);
  // ********************
  // strobe and strap
  // ********************
  int cnt_q = 0;

  initial strobe_n = 1'b1;

  // strap level, high selects the backed mode
  assign mode_sel = backed;

  // first kick just after reset, then every KICK_CYC cycles
  always @(posedge clk) begin
    if (in_reset || (!kick_en && cnt_q == 0)) begin
      cnt_q <= 0;
      strobe_n <= 1'b1;
    end else begin
      cnt_q <= (cnt_q == 0) ? KICK_CYC - 1 : cnt_q - 1;
      strobe_n <= (cnt_q != 0) && (cnt_q != KICK_CYC - 1);
    end
  end
endmodule
`default_nettype wire

/* verif/psr_top_tb.sv */
// Purpose : self-checking bench of the supervisor block
// Assumes : shortened counts, tick of four clock cycles
// Notes   : windows allow for synchroniser delay and partial ticks
`timescale 1ns/1ns
`default_nettype none
module psr_top_tb;
  // ********************
  // set-up
  // ********************
  localparam int T = 4;
  localparam int RT = 4;
  localparam int PT = 6;
  localparam int WT = 10;
  localparam int NT = 3;
  localparam int CT = 2;
  localparam int PB = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_low = 1'b1;
  logic below_bat = 1'b1;
  logic sense_low = 1'b1;
  logic open_st = 1'b0;
  logic pb_n = 1'b1;
  logic ce_in_n = 1'b1;
  logic kick_en = 1'b0;
  logic backed = 1'b0;
  logic strobe_n, mode_sel, rst_out, rst_out_n, irq_o, irq_oe, ce_out_n;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  psr_host_model #(.KICK_CYC(10)) u_host (
    .clk(clk), .in_reset(rst_out), .kick_en(kick_en), .backed(backed),
    .strobe_n(strobe_n), .mode_sel(mode_sel));

  psr_top #(
    .TICK_CYCLES(T), .RST_TICKS(RT), .PWRUP_TICKS(PT), .WDOG_TICKS(WT),
    .NMI_TICKS(NT), .CE_TICKS(CT), .PB_DEB_TICKS(PB)
  ) uut (
    .REF_CLK(clk), .RST(rst), .SUPPLY_LOW(sup_low),
    .SUPPLY_BELOW_BATTERY(below_bat), .SENSE_LOW(sense_low),
    .WATCHDOG_STROBE_N(strobe_n), .STROBE_OPEN(open_st),
    .PUSHBUTTON_RESET_N(pb_n), .RESET_MODE_SELECT(mode_sel),
    .CHIP_ENABLE_IN_N(ce_in_n), .RESET_OUT(rst_out),
    .RESET_OUT_N(rst_out_n), .INTERRUPT_N_O(irq_o),
    .INTERRUPT_N_OE(irq_oe), .CHIP_ENABLE_OUT_N(ce_out_n));

  // ********************
  // helpers
  // ********************
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, the whole run needs about 1200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input int n, input int lo, input int hi);
    check(8'(n >= lo && n <= hi), 8'h01);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return rst_out;
      1: return irq_o;
      default: return ce_out_n;
    endcase
  endfunction

  // n equals max when the level never showed up
  task automatic wait_for(input int sel, input logic val, input int max,
                          output int n);
    n = 0;
    while (n < max && probe(sel) !== val) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_powerup();
    int n;
    cyc(10);
    check(8'({rst_out, rst_out_n}), 8'h02);
    below_bat = 1'b0;
    wait_for(1, 1'b0, 30, n);
    check(8'(n), 8'h1E);
    sense_low = 1'b0;
    sup_low = 1'b0;
    wait_for(0, 1'b0, 60, n);
    in_range(n, (PT - 1) * T, (PT + 1) * T + 4);
    check(8'({rst_out, rst_out_n}), 8'h01);
    check(8'({irq_o, irq_oe}), 8'h03);
  endtask

  task automatic t_watchdog();
    int n;
    kick_en = 1'b1;
    wait_for(0, 1'b1, 150, n);
    check(8'(n), 8'h96);
    kick_en = 1'b0;
    wait_for(0, 1'b1, 80, n);
    in_range(n, (WT - 1) * T - 12, (WT + 1) * T + 6);
    wait_for(0, 1'b0, 40, n);
    in_range(n, (RT - 1) * T, (RT + 1) * T + 4);
    wait_for(0, 1'b1, 80, n);
    in_range(n, (WT - 1) * T, (WT + 1) * T + 6);
    wait_for(0, 1'b0, 40, n);
    open_st = 1'b1;
    wait_for(0, 1'b1, 120, n);
    check(8'(n), 8'h78);
    open_st = 1'b0;
    kick_en = 1'b1;
  endtask

  task automatic t_button();
    int n;
    pb_n = 1'b0;
    wait_for(0, 1'b1, 20, n);
    in_range(n, T, (PB + 1) * T + 4);
    cyc(8);
    pb_n = 1'b1;
    wait_for(0, 1'b0, 40, n);
    in_range(n, (RT - 1) * T, (RT + 1) * T + 6);
  endtask

  task automatic t_irq();
    int n;
    sense_low = 1'b1;
    cyc(T + 1);
    sense_low = 1'b0;
    wait_for(1, 1'b0, 30, n);
    check(8'(n), 8'h1E);
    sense_low = 1'b1;
    wait_for(1, 1'b0, 20, n);
    in_range(n, 2 * T, 3 * T + 6);
    wait_for(1, 1'b1, 30, n);
    in_range(n, (NT - 1) * T, (NT + 1) * T + 2);
    wait_for(1, 1'b0, 30, n);
    check(8'(n), 8'h1E);
    kick_en = 1'b0;
    wait_for(0, 1'b1, 80, n);
    check(8'(n < 80), 8'h01);
    wait_for(0, 1'b0, 40, n);
    sense_low = 1'b0;
    kick_en = 1'b1;
    cyc(10);
    sense_low = 1'b1;
    wait_for(1, 1'b0, 20, n);
    sense_low = 1'b0;
    wait_for(1, 1'b1, 6, n);
    check(8'(n <= 4), 8'h01);
  endtask

  task automatic t_backed();
    int n;
    backed = 1'b1;
    sense_low = 1'b1;
    kick_en = 1'b0;
    wait_for(0, 1'b1, 120, n);
    check(8'(n), 8'h78);
    pb_n = 1'b0;
    cyc(16);
    pb_n = 1'b1;
    wait_for(0, 1'b1, 30, n);
    check(8'(n), 8'h1E);
    kick_en = 1'b1;
    cyc(3);
    kick_en = 1'b0;
    wait_for(1, 1'b0, 10, n);
    check(8'(n < 10), 8'h01);
    cyc(30);
    sense_low = 1'b0;
    backed = 1'b0;
    kick_en = 1'b1;
  endtask

  task automatic t_fall();
    int n;
    // no kicks: in backed mode a late strobe with sense low would pulse the interrupt
    kick_en = 1'b0;
    for (int m = 0; m < 2; m++) begin
      backed = 1'(m);
      cyc(20);
      sense_low = 1'b1;
      sup_low = 1'b1;
      wait_for(1, 1'b0, 30, n);
      check(8'(n < 30), 8'(m == 0));
      check(8'(rst_out), 8'h01);
      sense_low = 1'b0;
      sup_low = 1'b0;
      wait_for(0, 1'b0, 60, n);
    end
    backed = 1'b0;
    kick_en = 1'b1;
  endtask

  task automatic t_ce();
    int n;
    ce_in_n = 1'b0;
    cyc(4);
    check(8'(ce_out_n), 8'h00);
    sup_low = 1'b1;
    cyc(5);
    check(8'(ce_out_n), 8'h00);
    ce_in_n = 1'b1;
    cyc(4);
    check(8'(ce_out_n), 8'h01);
    ce_in_n = 1'b0;
    cyc(8);
    check(8'(ce_out_n), 8'h01);
    sup_low = 1'b0;
    wait_for(0, 1'b0, 60, n);
    cyc(4);
    check(8'(ce_out_n), 8'h00);
    sup_low = 1'b1;
    wait_for(2, 1'b1, 30, n);
    in_range(n, (CT - 1) * T, (CT + 1) * T + 6);
    ce_in_n = 1'b1;
    sup_low = 1'b0;
    wait_for(0, 1'b0, 60, n);
  endtask

  task automatic t_battery();
    int n;
    for (int m = 0; m < 2; m++) begin
      backed = 1'(m);
      sup_low = 1'b1;
      below_bat = 1'b1;
      cyc(6);
      check(8'({irq_o, irq_oe}), 8'(2 + m));
      below_bat = 1'b0;
      sup_low = 1'b0;
      wait_for(0, 1'b0, 60, n);
    end
  endtask

  initial begin
    cyc(5);
    rst = 1'b0;
    t_powerup();
    t_watchdog();
    t_button();
    t_irq();
    t_backed();
    t_fall();
    t_ce();
    t_battery();
    close_out();
  end
endmodule
`default_nettype wire
